// >>> include/sps_pkg.sv
// package: constants shared by the stepper phase sequencer files
package sps_pkg;
   // ****************************************************
   // register map (byte addresses)
   // ****************************************************
   localparam logic [7:0] SPS_CTRL_ADDR = 8'h00;
   localparam logic [7:0] SPS_STATUS_ADDR = 8'h04;
   localparam logic [7:0] SPS_INT_STAT_ADDR = 8'h08;
   localparam logic [7:0] SPS_INT_CLR_ADDR = 8'h0c;
   localparam logic [7:0] SPS_INT_EN_ADDR = 8'h10;

   // ****************************************************
   // field positions and reset values
   // ****************************************************
   localparam int SPS_CTRL_BRIDGE_EN_BIT = 0;
   localparam logic [0:0] SPS_CTRL_RST = 1'h1;
   localparam int SPS_STAT_STATE_LSB = 0;
   localparam int SPS_STAT_ENLINE_BIT = 4;
   localparam int SPS_STAT_OC_BIT = 5;
   localparam int SPS_STAT_OT_BIT = 6;
   localparam int SPS_STAT_HALF_BIT = 7;
   localparam int SPS_STAT_CW_BIT = 8;
   localparam int SPS_EVT_STEP = 0;
   localparam int SPS_EVT_OC = 1;
   localparam int SPS_EVT_OT = 2;
   localparam int SPS_EVT_DISABLED = 3;
   localparam int SPS_NUM_EVT = 4;
   localparam logic [3:0] SPS_INT_EN_RST = 4'h0;

   // ****************************************************
   // sequencer state and drive table
   // ****************************************************
   localparam logic [3:0] SPS_STATE_RST = 4'h1;
   localparam logic [3:0] SPS_STATE_MAX = 4'h8;
   // per state (index = state-1), 4 bits {enA, phA, enB, phB}
   localparam logic [31:0] SPS_DRIVE_TBL = 32'hce2a8b3f;

   // ****************************************************
   // thermal trip point and hysteresis, degrees C
   // ****************************************************
   localparam logic [7:0] SPS_OT_TRIP_C = 8'ha5;
   localparam logic [7:0] SPS_OT_HYST_C = 8'h0f;
   localparam logic [7:0] SPS_OT_RELEASE_C = SPS_OT_TRIP_C - SPS_OT_HYST_C;

   // ****************************************************
   // axi responses
   // ****************************************************
   localparam logic [1:0] SPS_RESP_OKAY = 2'h0;
   localparam logic [1:0] SPS_RESP_SLVERR = 2'h2;
endpackage

// >>> design/sps_sync3.sv
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sps_sync3 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // pins in, filtered levels out
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] lvl_q;

   // ****************************************************
   // stages; a bit changes once stages two and three agree
   // ****************************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         lvl_q <= INIT;
      end else begin
         s1_q <= pinIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
      end
   end

   assign level = lvl_q;
endmodule
`default_nettype wire

// >>> design/sps_top.sv
// module: stepper phase sequencer with protection and axi4-lite registers
// Operation
// - bridge phase and enable outputs are decoded from the current state
// - state moves only on a step clock rising edge or a reset, direction chooses sense
// - sense high counts states up, low counts down, wrapping 8 and 1
// - power-up reset and the reset pin both force state 1
// - half step: one state per edge, up 1..8 or down 1,8,7..2
// - normal drive energises both phases, wave drive only one
// - full step from odd state: 1,3,5,7 up or 1,7,5,3 down
// - full step from even state: 2,4,6,8 up or 8,6,4,2 down
// - reset, one half-step edge, then full step gives wave from 2 or 8
// - any high side comparator at threshold raises an overcurrent fault
// - overcurrent pulls the shared enable line low through open drain
// - over-temperature switches bridges off until it cools by hysteresis
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sps_top
   import sps_pkg::*;
#(
   parameter int NUM_HS = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // host pins
   input wire logic stepClk,
   input wire logic halfFull,
   input wire logic rotation_sense_select,
   input wire logic seqReset_n,
   // overcurrent comparators and die temperature
   input wire logic [NUM_HS-1:0] overcurrent_detector,
   input wire logic [7:0] dieTempC,
   // shared enable line, open drain
   input wire logic enLineIn,
   output logic enLineOut,
   output logic enLineOe_n,
   // bridge controls
   output logic phaseA,
   output logic enableA,
   output logic phaseB,
   output logic enableB,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // interrupt
   output logic irq
);
   // ****************************************************
   // pin synchronisers
   // ****************************************************
   logic [NUM_HS+4:0] pinVec;
   logic [NUM_HS+4:0] pinLvl;
   logic stepLvl, halfLvl, cwLvl, seqRstLvl_n, enLvl;
   logic [NUM_HS-1:0] ocLvl;

   assign pinVec = {overcurrent_detector, enLineIn, seqReset_n,
                    rotation_sense_select, halfFull, stepClk};

   sps_sync3 #(
      .WIDTH(NUM_HS + 5),
      .INIT({{NUM_HS{1'b0}}, 5'h1c})
   ) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pinIn(pinVec),
      .level(pinLvl)
   );

   assign stepLvl = pinLvl[0];
   assign halfLvl = pinLvl[1];
   assign cwLvl = pinLvl[2];
   assign seqRstLvl_n = pinLvl[3];
   assign enLvl = pinLvl[4];
   assign ocLvl = pinLvl[NUM_HS+4:5];

   // ****************************************************
   // step clock edge and next state
   // ****************************************************
   logic stepPrev_q;
   logic stepRise;
   logic [3:0] state_q;
   logic [2:0] idx;
   logic [2:0] idxNext;
   logic [2:0] stride;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         stepPrev_q <= 1'b0;
      end else begin
         stepPrev_q <= stepLvl;
      end
   end

   assign stepRise = stepLvl & ~stepPrev_q;
   assign idx = 3'(state_q - 4'h1);
   assign stride = halfLvl ? 3'h1 : 3'h2;
   assign idxNext = cwLvl ? idx + stride : idx - stride;

   always_ff @(posedge ref_clk) begin
      if (!rst_n || !seqRstLvl_n) begin
         state_q <= SPS_STATE_RST;
      end else if (stepRise) begin
         state_q <= {1'b0, idxNext} + 4'h1;
      end
   end

   // ****************************************************
   // overcurrent: pull line low until the fault is gone and the line is seen low
   // ****************************************************
   logic ocFault;
   logic pull_q;

   assign ocFault = |ocLvl;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pull_q <= 1'b0;
      end else if (ocFault) begin
         pull_q <= 1'b1;
      end else if (!enLvl) begin
         pull_q <= 1'b0;
      end
   end

   assign enLineOut = 1'b0;
   assign enLineOe_n = ~pull_q;

   // ****************************************************
   // thermal trip with hysteresis
   // ****************************************************
   logic ot_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ot_q <= 1'b0;
      end else if (dieTempC >= SPS_OT_TRIP_C) begin
         ot_q <= 1'b1;
      end else if (dieTempC <= SPS_OT_RELEASE_C) begin
         ot_q <= 1'b0;
      end
   end

   // ****************************************************
   // bridge drive decode
   // ****************************************************
   logic bridgeEn_q;
   logic [3:0] drv;
   logic bridgeOn;

   assign drv = SPS_DRIVE_TBL[{idx, 2'b00} +: 4];
   assign bridgeOn = enLvl & ~ot_q & bridgeEn_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         enableA <= 1'b0;
         phaseA <= 1'b0;
         enableB <= 1'b0;
         phaseB <= 1'b0;
      end else begin
         enableA <= drv[3] & bridgeOn;
         phaseA <= drv[2];
         enableB <= drv[1] & bridgeOn;
         phaseB <= drv[0];
      end
   end

   // ****************************************************
   // interrupt events
   // ****************************************************
   logic [SPS_NUM_EVT-1:0] evt;
   logic [SPS_NUM_EVT-1:0] intStat_q;
   logic [SPS_NUM_EVT-1:0] intEn_q;
   logic [SPS_NUM_EVT-1:0] intClr;
   logic enPrev_q, otPrev_q, ocPrev_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         enPrev_q <= 1'b1;
         otPrev_q <= 1'b0;
         ocPrev_q <= 1'b0;
      end else begin
         enPrev_q <= enLvl;
         otPrev_q <= ot_q;
         ocPrev_q <= ocFault;
      end
   end

   always_comb begin
      evt = '0;
      evt[SPS_EVT_STEP] = stepRise;
      evt[SPS_EVT_OC] = ocFault & ~ocPrev_q;
      evt[SPS_EVT_OT] = ot_q & ~otPrev_q;
      evt[SPS_EVT_DISABLED] = enPrev_q & ~enLvl;
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         intStat_q <= '0;
      end else begin
         intStat_q <= (intStat_q & ~intClr) | evt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(intStat_q & intEn_q);
      end
   end

   // ****************************************************
   // axi4-lite write channel
   // ****************************************************
   logic wrTake;
   logic wrOk;

   assign wrTake = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wrTake;
   assign s_axi_wready = wrTake;
   assign wrOk = (s_axi_awaddr == SPS_CTRL_ADDR)
              || (s_axi_awaddr == SPS_INT_CLR_ADDR)
              || (s_axi_awaddr == SPS_INT_EN_ADDR);
   assign intClr = (wrTake && s_axi_awaddr == SPS_INT_CLR_ADDR
                    && s_axi_wstrb[0]) ? s_axi_wdata[SPS_NUM_EVT-1:0] : '0;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= SPS_RESP_OKAY;
      end else if (wrTake) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrOk ? SPS_RESP_OKAY : SPS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bridgeEn_q <= SPS_CTRL_RST;
         intEn_q <= SPS_INT_EN_RST;
      end else if (wrTake && s_axi_wstrb[0]) begin
         if (s_axi_awaddr == SPS_CTRL_ADDR) begin
            bridgeEn_q <= s_axi_wdata[SPS_CTRL_BRIDGE_EN_BIT];
         end
         if (s_axi_awaddr == SPS_INT_EN_ADDR) begin
            intEn_q <= s_axi_wdata[SPS_NUM_EVT-1:0];
         end
      end
   end

   // ****************************************************
   // axi4-lite read channel
   // ****************************************************
   logic [31:0] rdMux;
   logic rdOk;

   assign s_axi_arready = ~s_axi_rvalid;

   always_comb begin
      rdMux = '0;
      rdOk = 1'b1;
      case (s_axi_araddr)
         SPS_CTRL_ADDR: begin
            rdMux[SPS_CTRL_BRIDGE_EN_BIT] = bridgeEn_q;
         end
         SPS_STATUS_ADDR: begin
            rdMux[SPS_STAT_STATE_LSB +: 4] = state_q;
            rdMux[SPS_STAT_ENLINE_BIT] = enLvl;
            rdMux[SPS_STAT_OC_BIT] = ocFault;
            rdMux[SPS_STAT_OT_BIT] = ot_q;
            rdMux[SPS_STAT_HALF_BIT] = halfLvl;
            rdMux[SPS_STAT_CW_BIT] = cwLvl;
         end
         SPS_INT_STAT_ADDR: begin
            rdMux[SPS_NUM_EVT-1:0] = intStat_q;
         end
         SPS_INT_CLR_ADDR: begin
            rdMux = '0;
         end
         SPS_INT_EN_ADDR: begin
            rdMux[SPS_NUM_EVT-1:0] = intEn_q;
         end
         default: begin
            rdOk = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= SPS_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdMux;
         s_axi_rresp <= rdOk ? SPS_RESP_OKAY : SPS_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************************
   // assertions
   // ****************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_reset_state;
      !seqRstLvl_n |=> state_q == SPS_STATE_RST;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("reset pin did not force state 1");

   property p_hold_state;
      !stepRise && seqRstLvl_n |=> $stable(state_q);
   endproperty
   a_hold_state: assert property (p_hold_state)
      else $error("state moved without a step edge");

   property p_half_cw;
      stepRise && seqRstLvl_n && halfLvl && cwLvl |=>
         state_q == (($past(state_q) == 4'h8) ? 4'h1 : $past(state_q) + 4'h1);
   endproperty
   a_half_cw: assert property (p_half_cw)
      else $error("half step clockwise order wrong");

   property p_half_ccw;
      stepRise && seqRstLvl_n && halfLvl && !cwLvl |=>
         state_q == (($past(state_q) == 4'h1) ? 4'h8 : $past(state_q) - 4'h1);
   endproperty
   a_half_ccw: assert property (p_half_ccw)
      else $error("half step counterclockwise order wrong");

   property p_full_parity;
      stepRise && seqRstLvl_n && !halfLvl |=>
         state_q[0] == $past(state_q[0]) && state_q != $past(state_q);
   endproperty
   a_full_parity: assert property (p_full_parity)
      else $error("full step changed state parity");

   property p_full_ccw_even;
      stepRise && seqRstLvl_n && !halfLvl && !cwLvl && state_q == 4'h2 |=>
         state_q == 4'h8;
   endproperty
   a_full_ccw_even: assert property (p_full_ccw_even)
      else $error("wave drive did not wrap from 2 to 8");

   property p_range;
      state_q >= 4'h1 && state_q <= SPS_STATE_MAX;
   endproperty
   a_range: assert property (p_range)
      else $error("state outside 1 to 8");

   property p_phases_on;
      bridgeOn |=> (state_q[0] ? (enableA && enableB)
                                : (enableA ^ enableB)) || !$stable(state_q);
   endproperty
   a_phases_on: assert property (p_phases_on)
      else $error("wrong number of phases energised");

   property p_oc_pull;
      ocFault |=> !enLineOe_n && !enLineOut;
   endproperty
   a_oc_pull: assert property (p_oc_pull)
      else $error("overcurrent did not pull enable line");

   property p_disabled;
      !enLvl || ot_q |=> !enableA && !enableB;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("bridges on while disabled");

   property p_ot_hyst;
      ot_q && dieTempC > SPS_OT_RELEASE_C |=> ot_q;
   endproperty
   a_ot_hyst: assert property (p_ot_hyst)
      else $error("thermal flag released before hysteresis");

   c_wave: cover property (stepRise && !halfLvl && !state_q[0]);
   c_normal: cover property (stepRise && !halfLvl && state_q[0]);
   c_oc: cover property (ocFault ##1 !enLvl [*3] ##1 enLvl);
   c_irq: cover property (!irq ##1 irq);
endmodule
`default_nettype wire

// >>> tb/sps_host_model.sv
// host controller model driving the step, mode and reset pins
`timescale 1ns/1ps
`default_nettype none
module sps_host_model (
   // clock
   input wire logic ref_clk,
   // host pins
   output logic stepClk,
   output logic halfFull,
   output logic rotation_sense_select,
   output logic seqReset_n
);
   // ****************************************************
   // pin drivers
   // ****************************************************
   initial begin
      stepClk = 1'b0;
      halfFull = 1'b1;
      rotation_sense_select = 1'b1;
      seqReset_n = 1'b1;
   end

   // wait n rising edges with pins held
   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // one step pulse, high and low six cycles each
   task automatic step();
      stepClk <= 1'b1;
      hold(6);
      stepClk <= 1'b0;
      hold(6);
   endtask

   // mode pins change only between step pulses
   task automatic set_mode(input logic h, input logic cw);
      halfFull <= h;
      rotation_sense_select <= cw;
      hold(6);
   endtask

   // sequencer reset pulse
   task automatic pulse_reset();
      seqReset_n <= 1'b0;
      hold(6);
      seqReset_n <= 1'b1;
      hold(6);
   endtask
endmodule
`default_nettype wire

// >>> tb/sps_top_tb.sv
// self-checking bench for the stepper phase sequencer
`timescale 1ns/1ps
`default_nettype none
module sps_top_tb
   import sps_pkg::*;
;
   logic ref_clk, rst_n, enLineExt, enLineOut, enLineOe_n;
   logic stepClk, halfFull, rotation_sense_select, seqReset_n;
   logic [3:0] overcurrent_detector;
   logic [7:0] dieTempC, s_axi_awaddr, s_axi_araddr;
   logic phaseA, enableA, phaseB, enableB, irq;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   wire logic enLineIn;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;
   int expSt;
   logic [7:0] tmp [4] = '{8'ha4, 8'ha5, 8'h97, 8'h96};
   logic [1:0] ex [4] = '{2'h3, 2'h0, 2'h0, 2'h3};

   // open drain line with external pull-up
   assign enLineIn = enLineOe_n ? enLineExt : 1'b0;

   sps_top #(.NUM_HS(4)) uut (.ref_clk, .rst_n, .stepClk, .halfFull,
      .rotation_sense_select, .seqReset_n, .overcurrent_detector,
      .dieTempC, .enLineIn, .enLineOut, .enLineOe_n, .phaseA, .enableA,
      .phaseB, .enableB, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .irq);

   sps_host_model host (.ref_clk, .stepClk, .halfFull,
      .rotation_sense_select, .seqReset_n);

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt = error_cnt + 1;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      int n;
      logic awP, wP, done;
      n = 0;
      awP = 1'b1;
      wP = 1'b1;
      done = 1'b0;
      r = 2'h3;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done && n < 40) begin
         @(posedge ref_clk);
         n++;
         if (!awP && !wP && s_axi_bvalid) begin
            r = s_axi_bresp;
            done = 1'b1;
            s_axi_bready <= 1'b0;
         end
         if (awP && s_axi_awready) begin
            awP = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (wP && s_axi_wready) begin
            wP = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      chk("write answer", 32'h1, {31'h0, done});
      @(posedge ref_clk);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int n;
      logic arP, done;
      n = 0;
      arP = 1'b1;
      done = 1'b0;
      d = 32'h0;
      r = 2'h3;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done && n < 40) begin
         @(posedge ref_clk);
         n++;
         if (!arP && s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            done = 1'b1;
            s_axi_rready <= 1'b0;
         end
         if (arP && s_axi_arready) begin
            arP = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
      end
      chk("read answer", 32'h1, {31'h0, done});
      @(posedge ref_clk);
   endtask

   // compare state and bridge drive with the expected state
   task automatic chk_state();
      logic [3:0] t;
      t = SPS_DRIVE_TBL[(expSt-1)*4 +: 4];
      axi_rd(SPS_STATUS_ADDR, rd, rs);
      chk("state", expSt, {28'h0, rd[3:0]});
      chk("drive", {28'h0, t}, {enableA, phaseA, enableB, phaseB});
      chk("phases on", (expSt % 2) ? 2 : 1,
          {31'h0, enableA} + {31'h0, enableB});
   endtask

   // n steps with the expected state advanced per mode and sense
   task automatic seq(input int n);
      int d;
      for (int i = 0; i < n; i++) begin
         host.step();
         d = halfFull ? 1 : 2;
         expSt = rotation_sense_select ? (expSt - 1 + d) % 8 + 1
                                       : (expSt + 7 - d) % 8 + 1;
         chk_state();
      end
   endtask

   // ****************************************************
   // stimulus
   // ****************************************************
   initial begin
      rst_n = 1'b0;
      overcurrent_detector = 4'h0;
      dieTempC = 8'h19;
      enLineExt = 1'b1;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      axi_rd(SPS_CTRL_ADDR, rd, rs);
      chk("ctrl reset", 32'h1, {31'h0, rd[0]});
      axi_rd(SPS_INT_EN_ADDR, rd, rs);
      chk("int enable reset", 32'h0, {28'h0, rd[3:0]});
      axi_rd(8'h14, rd, rs);
      chk("unmapped read", {30'h0, SPS_RESP_SLVERR}, {30'h0, rs});
      axi_wr(SPS_STATUS_ADDR, 32'h5, rs);
      chk("read-only write", {30'h0, SPS_RESP_SLVERR}, {30'h0, rs});
      expSt = 1;
      chk_state();
      seq(9);
      host.set_mode(1'b1, 1'b0);
      seq(9);
      host.set_mode(1'b0, 1'b1);
      host.pulse_reset();
      expSt = 1;
      seq(5);
      host.set_mode(1'b0, 1'b0);
      seq(5);
      for (int c = 1; c >= 0; c--) begin
         host.set_mode(1'b1, c[0]);
         host.pulse_reset();
         expSt = 1;
         seq(1);
         host.set_mode(1'b0, c[0]);
         chk_state();
         seq(5);
      end
      host.pulse_reset();
      expSt = 1;
      chk_state();
      // interrupt raise, clear and mask
      axi_wr(SPS_INT_CLR_ADDR, 32'hf, rs);
      axi_wr(SPS_INT_EN_ADDR, 32'h1, rs);
      chk("write okay", {30'h0, SPS_RESP_OKAY}, {30'h0, rs});
      host.set_mode(1'b1, 1'b1);
      seq(1);
      chk("irq raised", 32'h1, {31'h0, irq});
      axi_wr(SPS_INT_CLR_ADDR, 32'h1, rs);
      repeat (2) @(posedge ref_clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      axi_wr(SPS_INT_EN_ADDR, 32'h0, rs);
      seq(1);
      chk("irq masked", 32'h0, {31'h0, irq});
      axi_rd(SPS_INT_STAT_ADDR, rd, rs);
      chk("step event", 32'h1, {31'h0, rd[SPS_EVT_STEP]});
      // overcurrent on one high side switch
      axi_wr(SPS_INT_CLR_ADDR, 32'hf, rs);
      overcurrent_detector <= 4'h4;
      repeat (14) @(posedge ref_clk);
      chk("pull low", 32'h0, {31'h0, enLineOe_n});
      chk("bridges off", 32'h0, {30'h0, enableA, enableB});
      overcurrent_detector <= 4'h0;
      repeat (16) @(posedge ref_clk);
      chk("pull released", 32'h1, {31'h0, enLineOe_n});
      chk_state();
      axi_rd(SPS_INT_STAT_ADDR, rd, rs);
      chk("fault events", 32'ha, rd & 32'he);
      // bridge enable bit of the control register
      axi_wr(SPS_CTRL_ADDR, 32'h0, rs);
      chk("ctrl off", 32'h0, {30'h0, enableA, enableB});
      axi_wr(SPS_CTRL_ADDR, 32'h1, rs);
      host.pulse_reset();
      expSt = 1;
      chk_state();
      for (int i = 0; i < 4; i++) begin
         dieTempC <= tmp[i];
         repeat (4) @(posedge ref_clk);
         chk("thermal gate", {30'h0, ex[i]}, {30'h0, enableA, enableB});
      end
      wrap_up();
   end
endmodule
`default_nettype wire
